// file: rtl/itc_core.sv
// Interrupt thread coprocessor: scheduler, core, bus access, semaphores
// ---------------------------------------------------------------
// Functional notes
// - Low level threads yield to levels 4-7
// - High level threads are never preempted
// - Preempted context saved and restored by hardware
// - Per-channel completion interrupt to host
// - Hardware semaphores shared with host
// - 16-bit datapath, transfers, bit ops, arithmetic
// - Own bus path; protected range waits
// - Host wins same resource, core stalls
// - At most two RAM accesses per host cycle
// - One peripheral or flash access per host cycle
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module itc_core #(
   parameter int N = itc_pkg::CHANNELS
) (
   input  wire logic                  clock,
   input  wire logic                  rst_n,
   input  wire logic [N-1:0]          chan_req,
   input  wire logic [N-1:0][2:0]     chan_level,
   output logic      [N-1:0]          chan_ack_q,
   output logic      [N-1:0]          host_irq_q,
   input  wire logic [N-1:0]          host_irq_clr,
   output itc_pkg::mem_req_t          mem_q,
   input  wire logic [15:0]           mem_rdata,
   input  wire logic                  host_ram_busy,
   input  wire logic                  host_bus_busy,
   input  wire logic                  host_idle,
   input  wire logic                  host_cycle,
   input  wire itc_pkg::sem_cmd_t     host_sem,
   output logic                       host_sem_ok_q,
   output logic [2*itc_pkg::SEMS-1:0] sem_owner_q,
   output logic                       busy_q
);
   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   itc_pkg::core_state_t state_q, state_d;
   logic [15:0] pc_q, pc_d, ir_q, ir_d, save_pc_q, save_pc_d;
   logic [3:0]  ccr_q, ccr_d, save_ccr_q, save_ccr_d;
   logic [2:0]  lvl_q, lvl_d, save_lvl_q, save_lvl_d;
   logic [$clog2(N)-1:0] ch_q, ch_d, save_ch_q, save_ch_d;
   logic        bank_q, bank_d;
   logic [1:0]  ram_cnt_q, ram_cnt_d, bus_cnt_q, bus_cnt_d;
   itc_pkg::mem_req_t mem_d;
   logic [N-1:0] ack_d, sif_set;
   logic        busy_d, sem_ok_d, sem_ok_core;
   logic [2*itc_pkg::SEMS-1:0] sem_d;
   logic [15:0] ra, rb, wdat, ea, alu;
   logic        rf_we;
   logic [2:0]  ra_sel;
   logic [2:0]  best_lvl;
   logic [$clog2(N)-1:0] best_ch;
   logic        allowed, is_ram;
   logic [1:0]  ram_base, bus_base;
   logic [16:0] sum;
   logic        carry_in;
   itc_pkg::opcode_t op;
   logic [2:0]  rd, rs1, rs2;
   logic [7:0]  imm;

   assign op  = itc_pkg::opcode_t'(ir_q[15:12]);
   assign rd  = ir_q[11:9];
   assign rs1 = ir_q[8:6];
   assign rs2 = ir_q[5:3];
   assign imm = ir_q[7:0];
   // Destination doubles as source for partial and bit updates
   assign ra_sel = (op == itc_pkg::OP_LDH || op == itc_pkg::OP_BSET || op == itc_pkg::OP_BCLR
                    || op == itc_pkg::OP_STW) ? rd : rs1;

   itc_regfile #(.REGS(8)) u_rf (
      .clock   (clock),
      .bank    (bank_q),
      .ra_addr (ra_sel),
      .rb_addr (rs2),
      .ra_q    (ra),
      .rb_q    (rb),
      .we      (rf_we),
      .w_addr  (rd),
      .w_data  (wdat)
   );

   // ---------------------------------------------------------------
   // Arbitration among pending channels
   // ---------------------------------------------------------------
   always_comb
   begin
      best_lvl = 3'h0;
      best_ch  = '0;
      for (int i = N - 1; i >= 0; i--)
      begin
         if (chan_req[i] && chan_level[i] >= itc_pkg::LOW_MIN && chan_level[i] >= best_lvl)
         begin
            best_lvl = chan_level[i];
            best_ch  = ($clog2(N))'(i);
         end
      end
   end

   // ---------------------------------------------------------------
   // Bus access budget and conflicts
   // ---------------------------------------------------------------
   always_comb
   begin
      ea       = (state_q == itc_pkg::S_FETCH) ? pc_q : ra + rb;
      // Stale store word in ir must not move the fetch address
      if (state_q != itc_pkg::S_FETCH && op == itc_pkg::OP_STW)
      begin
         ea = rs1 == itc_pkg::ZERO_IDX ? rb : rb + {13'h0, rs1};
      end
      is_ram   = ea[15:14] == itc_pkg::REG_RAM;
      ram_base = host_cycle ? 2'h0 : ram_cnt_q;
      bus_base = host_cycle ? 2'h0 : bus_cnt_q;
      allowed  = is_ram ? (!host_ram_busy && ram_base < itc_pkg::RAM_BUDGET)
                        : (!host_bus_busy && bus_base < itc_pkg::BUS_BUDGET);
      if (ea[15:14] == itc_pkg::REG_PRR)
      begin
         allowed = allowed && host_idle;
      end
   end

   // ---------------------------------------------------------------
   // Core sequencing
   // ---------------------------------------------------------------
   always_comb
   begin
      state_d = state_q;  pc_d = pc_q;  ir_d = ir_q;  ccr_d = ccr_q;
      lvl_d = lvl_q;  ch_d = ch_q;  bank_d = bank_q;
      save_pc_d = save_pc_q;  save_ccr_d = save_ccr_q;
      save_lvl_d = save_lvl_q;  save_ch_d = save_ch_q;
      ram_cnt_d = ram_base;  bus_cnt_d = bus_base;
      mem_d = '0;  ack_d = '0;  sif_set = '0;
      rf_we = 1'b0;  wdat = 16'h0;  sum = 17'h0;  carry_in = 1'b0;
      alu = ra;
      case (state_q)
         itc_pkg::S_IDLE:
         begin
            if (best_lvl != 3'h0)
            begin
               lvl_d = best_lvl;  ch_d = best_ch;  ack_d[best_ch] = 1'b1;
               pc_d = 16'(best_ch) << itc_pkg::VEC_SHIFT;
               ccr_d = 4'h0;  bank_d = 1'b0;
               state_d = itc_pkg::S_FETCH;
            end
         end
         itc_pkg::S_FETCH:
         begin
            if (!bank_q && lvl_q < itc_pkg::HIGH_LEVEL && best_lvl >= itc_pkg::HIGH_LEVEL)
            begin
               save_pc_d = pc_q;  save_ccr_d = ccr_q;
               save_lvl_d = lvl_q;  save_ch_d = ch_q;
               bank_d = 1'b1;  lvl_d = best_lvl;  ch_d = best_ch;  ack_d[best_ch] = 1'b1;
               pc_d = 16'(best_ch) << itc_pkg::VEC_SHIFT;  ccr_d = 4'h0;
            end
            else if (allowed)
            begin
               mem_d = '{strobe: 1'b1, we: 1'b0, addr: ea, wdata: 16'h0};
               if (is_ram) ram_cnt_d = ram_base + 2'h1;
               else bus_cnt_d = bus_base + 2'h1;
               state_d = itc_pkg::S_FWAIT;
            end
         end
         itc_pkg::S_FWAIT:
         begin
            ir_d = mem_rdata;  pc_d = pc_q + 16'h1;  state_d = itc_pkg::S_READ;
         end
         itc_pkg::S_READ: state_d = itc_pkg::S_EXEC;
         itc_pkg::S_EXEC:
         begin
            state_d = itc_pkg::S_FETCH;
            case (op)
               itc_pkg::OP_ADD, itc_pkg::OP_SUB:
               begin
                  carry_in = op == itc_pkg::OP_SUB;
                  sum = {1'b0, ra} + {1'b0, carry_in ? ~rb : rb} + {16'h0, carry_in};
                  alu = sum[15:0];  rf_we = 1'b1;
                  ccr_d[itc_pkg::CC_C] = carry_in ? !sum[16] : sum[16];
                  ccr_d[itc_pkg::CC_V] = (ra[15] == (carry_in ? !rb[15] : rb[15])) && (alu[15] != ra[15]);
               end
               itc_pkg::OP_AND:  begin alu = ra & rb;  rf_we = 1'b1; end
               itc_pkg::OP_OR:   begin alu = ra | rb;  rf_we = 1'b1; end
               itc_pkg::OP_XOR:  begin alu = ra ^ rb;  rf_we = 1'b1; end
               itc_pkg::OP_LDL:  begin alu = {8'h0, imm};  rf_we = 1'b1; end
               itc_pkg::OP_LDH:  begin alu = {imm, ra[7:0]};  rf_we = 1'b1; end
               itc_pkg::OP_BSET: begin alu = ra | (16'h1 << imm[3:0]);  rf_we = 1'b1; end
               itc_pkg::OP_BCLR: begin alu = ra & ~(16'h1 << imm[3:0]);  rf_we = 1'b1; end
               itc_pkg::OP_LDW, itc_pkg::OP_STW: state_d = itc_pkg::S_MEM;
               itc_pkg::OP_BEQ:
                  if (ccr_q[itc_pkg::CC_Z]) pc_d = pc_q + {{8{imm[7]}}, imm};
               itc_pkg::OP_BNE:
                  if (!ccr_q[itc_pkg::CC_Z]) pc_d = pc_q + {{8{imm[7]}}, imm};
               itc_pkg::OP_SIF:  sif_set[ch_q] = 1'b1;
               itc_pkg::OP_SEM:  ccr_d[itc_pkg::CC_C] = sem_ok_core;
               itc_pkg::OP_RTS:
               begin
                  if (bank_q)
                  begin
                     bank_d = 1'b0;  pc_d = save_pc_q;  ccr_d = save_ccr_q;
                     lvl_d = save_lvl_q;  ch_d = save_ch_q;
                  end
                  else
                  begin
                     state_d = itc_pkg::S_IDLE;  lvl_d = 3'h0;
                  end
               end
               default: state_d = itc_pkg::S_FETCH;
            endcase
            if (rf_we)
            begin
               ccr_d[itc_pkg::CC_N] = alu[15];
               ccr_d[itc_pkg::CC_Z] = alu == 16'h0;
            end
         end
         itc_pkg::S_MEM:
         begin
            if (allowed)
            begin
               mem_d = '{strobe: 1'b1, we: op == itc_pkg::OP_STW, addr: ea, wdata: ra};
               if (is_ram) ram_cnt_d = ram_base + 2'h1;
               else bus_cnt_d = bus_base + 2'h1;
               state_d = itc_pkg::S_MWAIT;
            end
         end
         itc_pkg::S_MWAIT:
         begin
            rf_we = op == itc_pkg::OP_LDW;  state_d = itc_pkg::S_FETCH;
         end
         default: state_d = itc_pkg::S_IDLE;
      endcase
      wdat = (state_q == itc_pkg::S_MWAIT) ? mem_rdata : alu;
      busy_d = state_d != itc_pkg::S_IDLE;
   end

   // ---------------------------------------------------------------
   // Semaphores; host wins a same-cycle tie on one index
   // ---------------------------------------------------------------
   always_comb
   begin
      logic [1:0] own;
      own = 2'h0;
      sem_d = sem_owner_q;
      sem_ok_d = 1'b0;
      sem_ok_core = 1'b0;
      if (host_sem.req)
      begin
         own = sem_owner_q[2*host_sem.idx +: 2];
         if (host_sem.set && own != itc_pkg::OWN_CORE)
         begin
            sem_d[2*host_sem.idx +: 2] = itc_pkg::OWN_HOST;
            sem_ok_d = 1'b1;
         end
         else if (!host_sem.set && own == itc_pkg::OWN_HOST)
         begin
            sem_d[2*host_sem.idx +: 2] = itc_pkg::OWN_FREE;
            sem_ok_d = 1'b1;
         end
      end
      if (state_q == itc_pkg::S_EXEC && op == itc_pkg::OP_SEM
          && !(host_sem.req && host_sem.idx == imm[2:0]))
      begin
         own = sem_owner_q[2*imm[2:0] +: 2];
         if (imm[3] && own != itc_pkg::OWN_HOST)
         begin
            sem_d[2*imm[2:0] +: 2] = itc_pkg::OWN_CORE;
            sem_ok_core = 1'b1;
         end
         else if (!imm[3] && own == itc_pkg::OWN_CORE)
         begin
            sem_d[2*imm[2:0] +: 2] = itc_pkg::OWN_FREE;
            sem_ok_core = 1'b1;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state_q <= itc_pkg::S_IDLE;  pc_q <= 16'h0;  ir_q <= 16'h0;  ccr_q <= 4'h0;
         lvl_q <= 3'h0;  ch_q <= '0;  bank_q <= 1'b0;
         save_pc_q <= 16'h0;  save_ccr_q <= 4'h0;  save_lvl_q <= 3'h0;  save_ch_q <= '0;
         ram_cnt_q <= 2'h0;  bus_cnt_q <= 2'h0;  mem_q <= '0;
         chan_ack_q <= '0;  host_sem_ok_q <= 1'b0;  sem_owner_q <= '0;  busy_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;  pc_q <= pc_d;  ir_q <= ir_d;  ccr_q <= ccr_d;
         lvl_q <= lvl_d;  ch_q <= ch_d;  bank_q <= bank_d;
         save_pc_q <= save_pc_d;  save_ccr_q <= save_ccr_d;
         save_lvl_q <= save_lvl_d;  save_ch_q <= save_ch_d;
         ram_cnt_q <= ram_cnt_d;  bus_cnt_q <= bus_cnt_d;  mem_q <= mem_d;
         chan_ack_q <= ack_d;  host_sem_ok_q <= sem_ok_d;  sem_owner_q <= sem_d;  busy_q <= busy_d;
      end
   end

   // Completion flags: a new set beats a same-cycle clear
   for (genvar g = 0; g < N; g++)
   begin : g_irq
      logic irq_d;
      always_comb irq_d = sif_set[g] | (host_irq_q[g] & ~host_irq_clr[g]);
      always_ff @(posedge clock)
      begin
         if (!rst_n) host_irq_q[g] <= 1'b0;
         else host_irq_q[g] <= irq_d;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   a_low_preempted: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == itc_pkg::S_FETCH && !bank_q && lvl_q < itc_pkg::HIGH_LEVEL
      && best_lvl >= itc_pkg::HIGH_LEVEL |=> bank_q && lvl_q >= itc_pkg::HIGH_LEVEL)
      else $error("low thread not preempted");
   a_high_kept: assert property (@(posedge clock) disable iff (!rst_n)
      state_q != itc_pkg::S_IDLE && lvl_q >= itc_pkg::HIGH_LEVEL && !(state_q == itc_pkg::S_EXEC
      && op == itc_pkg::OP_RTS) |=> $stable(ch_q) && $stable(bank_q))
      else $error("high thread preempted");
   a_ctx_restore: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == itc_pkg::S_EXEC && op == itc_pkg::OP_RTS && bank_q
      |=> pc_q == $past(save_pc_q) && ccr_q == $past(save_ccr_q) && !bank_q)
      else $error("context not restored");
   a_irq_raise: assert property (@(posedge clock) disable iff (!rst_n)
      state_q == itc_pkg::S_EXEC && op == itc_pkg::OP_SIF |=> host_irq_q[$past(ch_q)])
      else $error("completion interrupt missing");
   a_sem_owner: assert property (@(posedge clock) disable iff (!rst_n)
      host_sem_ok_q |-> sem_owner_q[2*$past(host_sem.idx) +: 2] != itc_pkg::OWN_CORE)
      else $error("semaphore granted twice");
   a_host_first: assert property (@(posedge clock) disable iff (!rst_n)
      mem_q.strobe |-> (mem_q.addr[15:14] == itc_pkg::REG_RAM) ? !$past(host_ram_busy) : !$past(host_bus_busy))
      else $error("core took a busy resource");
   a_ram_rate: assert property (@(posedge clock) disable iff (!rst_n)
      ram_cnt_q <= itc_pkg::RAM_BUDGET)
      else $error("ram budget exceeded");
   a_bus_rate: assert property (@(posedge clock) disable iff (!rst_n)
      mem_q.strobe && mem_q.addr[15:14] != itc_pkg::REG_RAM |-> bus_cnt_q == itc_pkg::BUS_BUDGET)
      else $error("bus budget exceeded");
endmodule
`default_nettype wire

// file: common/itc_pkg.sv
// Shared constants and types of the interrupt thread coprocessor
package itc_pkg;
   localparam int          DW          = 16;
   localparam int          CHANNELS    = 8;
   localparam int          SEMS        = 8;
   localparam logic [2:0]  HIGH_LEVEL  = 3'h4;
   localparam logic [2:0]  LOW_MIN     = 3'h1;
   localparam logic [1:0]  RAM_BUDGET  = 2'h2;
   localparam logic [1:0]  BUS_BUDGET  = 2'h1;
   localparam int          VEC_SHIFT   = 6;
   localparam logic [15:0] RESET_WORD  = 16'h0000;
   localparam logic [2:0]  ZERO_IDX    = 3'h0;
   localparam logic [2:0]  DPTR_IDX    = 3'h1;
   localparam logic [2:0]  SPTR_IDX    = 3'h7;
   // Address region in the top two bits
   localparam logic [1:0]  REG_RAM     = 2'h0;
   localparam logic [1:0]  REG_PERIPH  = 2'h1;
   localparam logic [1:0]  REG_FLASH   = 2'h2;
   localparam logic [1:0]  REG_PRR     = 2'h3;
   // Flags in the condition code word
   localparam int          CC_N = 3;
   localparam int          CC_Z = 2;
   localparam int          CC_V = 1;
   localparam int          CC_C = 0;

   typedef enum logic [3:0] {
      OP_ADD = 4'h0, OP_SUB = 4'h1, OP_AND = 4'h2, OP_OR  = 4'h3,
      OP_XOR = 4'h4, OP_LDL = 4'h5, OP_LDH = 4'h6, OP_BSET = 4'h7,
      OP_BCLR = 4'h8, OP_LDW = 4'h9, OP_STW = 4'ha, OP_BEQ = 4'hb,
      OP_SIF = 4'hc, OP_SEM = 4'hd, OP_RTS = 4'he, OP_BNE = 4'hf
   } opcode_t;

   typedef enum logic [6:0] {
      S_IDLE  = 7'h01, S_FETCH = 7'h02, S_FWAIT = 7'h04, S_READ = 7'h08,
      S_EXEC  = 7'h10, S_MEM   = 7'h20, S_MWAIT = 7'h40
   } core_state_t;

   typedef enum logic [1:0] {
      OWN_FREE = 2'h0, OWN_HOST = 2'h1, OWN_CORE = 2'h2
   } sem_owner_t;

   typedef struct packed {
      logic        strobe;
      logic        we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } mem_req_t;

   typedef struct packed {
      logic       req;
      logic       set;
      logic [2:0] idx;
   } sem_cmd_t;
endpackage

// file: rtl/itc_regfile.sv
// Banked register file with registered read ports
`timescale 1ns/1ps
`default_nettype none
module itc_regfile #(
   parameter int REGS = 8
) (
   input  wire logic        clock,
   input  wire logic        bank,
   input  wire logic [2:0]  ra_addr,
   input  wire logic [2:0]  rb_addr,
   output logic      [15:0] ra_q,
   output logic      [15:0] rb_q,
   input  wire logic        we,
   input  wire logic [2:0]  w_addr,
   input  wire logic [15:0] w_data
);
   // Second bank holds the preempting thread, so the first stays intact
   logic [15:0] mem [2*REGS];
   logic [15:0] ra_d;
   logic [15:0] rb_d;

   always_comb
   begin
      ra_d = (ra_addr == itc_pkg::ZERO_IDX) ? itc_pkg::RESET_WORD : mem[{bank, ra_addr}];
      rb_d = (rb_addr == itc_pkg::ZERO_IDX) ? itc_pkg::RESET_WORD : mem[{bank, rb_addr}];
   end

   always_ff @(posedge clock)
   begin
      if (we && w_addr != itc_pkg::ZERO_IDX)
      begin
         mem[{bank, w_addr}] <= w_data;
      end
      ra_q <= ra_d;
      rb_q <= rb_d;
   end
endmodule
`default_nettype wire

// file: tb/itc_host_model.sv
// Host side model: shared word memory and host bus cycle pulses
`timescale 1ns/1ps
`default_nettype none
module itc_host_model #(
   parameter int HOST_DIV = 16
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire itc_pkg::mem_req_t mem_in,
   output logic [15:0]            mem_rdata,
   output logic                   host_cycle
);
   // ---------------------------------------------
   // Memory image: filler load-low immediate word, short threads
   // ---------------------------------------------
   logic [15:0] ram [0:511];
   logic [15:0] last_q;
   int          div_q;
   initial
   begin
      last_q = 16'h0000;
      for (int i = 0; i < 512; i++)
         ram[i] = 16'h5400;
      ram[9'h080] = 16'hc000;
      ram[9'h081] = 16'he000;
      ram[9'h0c0] = 16'hd00a;
      ram[9'h0c1] = 16'h5200;
      ram[9'h0c2] = 16'h6240;
      ram[9'h0c3] = 16'h9440;
      ram[9'h0c4] = 16'h62c0;
      ram[9'h0c5] = 16'h9440;
      ram[9'h0c6] = 16'he000;
      ram[9'h140] = 16'hc000;
      ram[9'h141] = 16'he000;
      ram[9'h194] = 16'he000;
      ram[9'h1c0] = 16'he000;
   end
   // ---------------------------------------------
   // Bus answer and host cycle divider
   // ---------------------------------------------
   // Off-strobe data flips each cycle so stale data never looks valid
   assign mem_rdata  = mem_in.strobe ? ram[mem_in.addr[8:0]] : ~last_q;
   assign host_cycle = (div_q == 0);
   always @(posedge clock)
   begin
      last_q <= mem_rdata;
      div_q  <= (!rst_n || div_q == HOST_DIV - 1) ? 0 : div_q + 1;
      if (mem_in.strobe && mem_in.we)
         ram[mem_in.addr[8:0]] <= mem_in.wdata;
   end
endmodule
`default_nettype wire

// file: tb/interrupt_thread_coprocessor_bench.sv
// Self-checking bench for the interrupt thread coprocessor
`timescale 1ns/1ps
`default_nettype none
module interrupt_thread_coprocessor_bench;
   // ---------------------------------------------
   // Signals and instances
   // ---------------------------------------------
   localparam int LIMIT = 20000;
   logic              clock;
   logic              rst_n;
   logic [7:0]        chan_req;
   logic [7:0][2:0]   chan_level;
   logic [7:0]        chan_ack_q;
   logic [7:0]        host_irq_q;
   logic [7:0]        host_irq_clr;
   itc_pkg::mem_req_t mem_q;
   logic [15:0]       mem_rdata;
   logic              host_ram_busy;
   logic              host_bus_busy;
   logic              host_idle;
   logic              host_cycle;
   itc_pkg::sem_cmd_t host_sem;
   logic              host_sem_ok_q;
   logic [15:0]       sem_owner_q;
   logic              busy_q;
   logic [15:0]       last_addr;
   int                n_strobe;
   int                win_cnt;
   int                win_last;
   logic              hc_d;
   int                cycles;
   int                num_errors;
   int                checked;

   itc_core #(.N(8)) u_dut (
      .clock         (clock),
      .rst_n         (rst_n),
      .chan_req      (chan_req),
      .chan_level    (chan_level),
      .chan_ack_q    (chan_ack_q),
      .host_irq_q    (host_irq_q),
      .host_irq_clr  (host_irq_clr),
      .mem_q         (mem_q),
      .mem_rdata     (mem_rdata),
      .host_ram_busy (host_ram_busy),
      .host_bus_busy (host_bus_busy),
      .host_idle     (host_idle),
      .host_cycle    (host_cycle),
      .host_sem      (host_sem),
      .host_sem_ok_q (host_sem_ok_q),
      .sem_owner_q   (sem_owner_q),
      .busy_q        (busy_q)
   );
   itc_host_model #(.HOST_DIV(16)) u_host (
      .clock      (clock),
      .rst_n      (rst_n),
      .mem_in     (mem_q),
      .mem_rdata  (mem_rdata),
      .host_cycle (host_cycle)
   );
   // ---------------------------------------------
   // Clock, strobe bookkeeping, hang guard
   // ---------------------------------------------
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Window lags the host pulse by one edge: strobe is registered
   always @(posedge clock)
   begin
      if (mem_q.strobe === 1'b1)
      begin
         last_addr <= mem_q.addr;
         n_strobe  <= n_strobe + 1;
      end
      hc_d     <= host_cycle;
      win_cnt  <= hc_d ? int'(mem_q.strobe === 1'b1) : win_cnt + int'(mem_q.strobe === 1'b1);
      win_last <= hc_d ? win_cnt : win_last;
      cycles   <= cycles + 1;
      if (cycles == LIMIT)
      begin
         num_errors++;
         conclude();
      end
   end
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic conclude();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wait_for(input int kind, input int ch, input int lim, output logic seen);
      seen = 1'b0;
      for (int i = 0; i < lim && !seen; i++)
      begin
         @(posedge clock);
         #1;
         case (kind)
            0: seen = (chan_ack_q[ch] === 1'b1);
            1: seen = (host_irq_q[ch] === 1'b1);
            default: seen = (busy_q === 1'b0);
         endcase
      end
   endtask
   task automatic start_thread(input int ch, input logic [2:0] lvl);
      logic s;
      @(posedge clock);
      chan_level[ch] <= lvl;
      chan_req[ch]   <= 1'b1;
      wait_for(0, ch, 20, s);
      check_val("thread_ack", 16'h0001, 16'(s));
      @(posedge clock);
      chan_req[ch] <= 1'b0;
   endtask
   task automatic next_addr(output logic [15:0] a);
      int n0;
      n0 = n_strobe;
      for (int i = 0; i < 60 && n_strobe == n0; i++)
      begin
         @(posedge clock);
         #1;
      end
      a = last_addr;
   endtask
   task automatic finish_irq(input int ch, input int lim);
      logic s;
      wait_for(1, ch, lim, s);
      check_val("irq_set", 16'h0001, 16'(s));
      @(posedge clock);
      host_irq_clr[ch] <= 1'b1;
      @(posedge clock);
      host_irq_clr[ch] <= 1'b0;
      wait_for(2, 0, 40, s);
      check_val("irq_clear", 16'h0000, 16'(host_irq_q[ch]));
   endtask
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_start();
      logic [15:0] a;
      start_thread(2, 3'h1);
      next_addr(a);
      check_val("start_pc", 16'h0080, a);
      finish_irq(2, 100);
   endtask
   task automatic t_preempt();
      logic [15:0] a;
      start_thread(1, 3'h2);
      repeat (24) @(posedge clock);
      start_thread(5, 3'h5);
      next_addr(a);
      check_val("preempt_pc", 16'h0140, a);
      finish_irq(5, 100);
      next_addr(a);
      check_val("resume_chan", 16'h0001, {6'h00, a[15:6]});
      finish_irq(1, 1500);
   endtask
   task automatic t_no_preempt();
      logic s;
      int   acks;
      acks = 0;
      start_thread(6, 3'h6);
      chan_level[7] <= 3'h7;
      chan_req[7]   <= 1'b1;
      repeat (40)
      begin
         @(posedge clock);
         #1;
         acks += int'(chan_ack_q[7] === 1'b1);
      end
      check_val("high_kept", 16'h0000, 16'(acks));
      wait_for(0, 7, 800, s);
      check_val("later_ack", 16'h0001, 16'(s));
      @(posedge clock);
      chan_req[7] <= 1'b0;
      wait_for(2, 0, 100, s);
   endtask
   task automatic t_host_wins();
      logic [15:0] a;
      logic        s;
      int          n0;
      start_thread(6, 3'h6);
      repeat (40) @(posedge clock);
      check_val("ram_budget", 16'h0001, 16'(win_last <= 2));
      host_ram_busy <= 1'b1;
      repeat (2) @(posedge clock);
      n0 = n_strobe;
      repeat (16) @(posedge clock);
      #1;
      check_val("core_stalled", 16'(n0), 16'(n_strobe));
      @(posedge clock);
      host_ram_busy <= 1'b0;
      next_addr(a);
      check_val("core_resumed", 16'h0006, {6'h00, a[15:6]});
      wait_for(2, 0, 800, s);
      check_val("thread_done", 16'h0001, 16'(s));
   endtask
   // Thread 3 takes semaphore 2, then loads from peripheral and protected space
   task automatic t_bus();
      logic [15:0] a;
      logic        s;
      start_thread(3, 3'h1);
      host_bus_busy <= 1'b1;
      host_idle     <= 1'b0;
      repeat (60) @(posedge clock);
      #1;
      check_val("bus_stalled", 16'h0000, {14'h0, last_addr[15:14]});
      @(posedge clock);
      host_bus_busy <= 1'b0;
      next_addr(a);
      check_val("periph_addr", 16'h4000, a);
      repeat (60) @(posedge clock);
      #1;
      check_val("prr_held", 16'h0000, {14'h0, last_addr[15:14]});
      @(posedge clock);
      host_idle <= 1'b1;
      next_addr(a);
      check_val("prr_addr", 16'hc000, a);
      wait_for(2, 0, 200, s);
      check_val("bus_done", 16'h0001, 16'(s));
      sem_op(1'b1, 3'h2, 1'b0, 2'h2);
      sem_op(1'b0, 3'h2, 1'b0, 2'h2);
   endtask
   task automatic sem_op(input logic set, input logic [2:0] idx, input logic ok, input logic [1:0] own);
      @(posedge clock);
      host_sem <= '{req: 1'b1, set: set, idx: idx};
      @(posedge clock);
      host_sem <= '0;
      #1;
      check_val("sem_ok", 16'(ok), 16'(host_sem_ok_q));
      check_val("sem_owner", 16'(own), 16'(sem_owner_q[2*idx +: 2]));
   endtask
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial
   begin
      rst_n = 1'b0;
      chan_req = '0;
      chan_level = '0;
      host_irq_clr = '0;
      host_ram_busy = 1'b0;
      host_bus_busy = 1'b0;
      host_idle = 1'b1;
      host_sem = '0;
      n_strobe = 0;
      win_cnt = 0;
      win_last = 0;
      hc_d = 1'b0;
      last_addr = 16'h0000;
      cycles = 0;
      num_errors = 0;
      checked = 0;
      repeat (4) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      check_val("reset_busy", 16'h0000, 16'(busy_q));
      check_val("reset_sems", 16'h0000, sem_owner_q);
      t_start();
      t_preempt();
      t_no_preempt();
      t_host_wins();
      t_bus();
      sem_op(1'b1, 3'h3, 1'b1, 2'h1);
      sem_op(1'b1, 3'h3, 1'b1, 2'h1);
      sem_op(1'b0, 3'h5, 1'b0, 2'h0);
      sem_op(1'b0, 3'h3, 1'b1, 2'h0);
      conclude();
   end
endmodule
`default_nettype wire
